// ### dv/nvm_dev_model.sv
/* Device model: command, address and data loads, page buffer, flash, EEPROM, fuses, timed ready/busy.
   Assumes pins driven by the host controller, one clock. */
`timescale 1ns/10ps
`default_nettype none
module nvm_dev_model #(parameter int BUSY = 20) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic action_sel_hi,
    input wire logic action_sel_lo,
    input wire logic byte_sel_lo,
    input wire logic byte_sel_hi,
    input wire logic page_latch_strobe,
    input wire logic load_strobe,
    input wire logic write_n,
    input wire logic output_enable_n,
    input wire logic [7:0] data_out,
    output logic [7:0] data_in,
    output logic ready_busy_out
);
    logic [7:0] cmd, alo, ahi, dlo, dhi, rdv, last;
    logic [15:0] pb [256];
    logic [15:0] fl [256];
    logic [7:0] ee [256];
    logic [7:0] fuse [3];
    logic ld_q, pl_q, wn_q;
    int busy;
    wire [1:0] bs = {byte_sel_hi, byte_sel_lo};
    wire [1:0] act = {action_sel_hi, action_sel_lo};
    assign ready_busy_out = busy == 0;
    assign rdv = cmd == 8'h03 ? ee[alo] : byte_sel_lo ? fl[alo][15:8] : fl[alo][7:0];
    assign data_in = output_enable_n ? ~last : rdv;
    always @(posedge aclk) begin
        ld_q <= load_strobe;
        pl_q <= page_latch_strobe;
        wn_q <= write_n;
        if (!output_enable_n) last <= rdv;
        if (busy > 0) busy <= busy - 1;
        if (load_strobe && !ld_q) begin
            if (act == 2'h2 && !byte_sel_lo) cmd <= data_out;
            if (act == 2'h0 && bs == 2'h0) alo <= data_out;
            if (act == 2'h0 && bs == 2'h1) ahi <= data_out;
            if (act == 2'h1 && byte_sel_lo) dhi <= data_out;
            if (act == 2'h1 && !byte_sel_lo) dlo <= data_out;
        end
        if (page_latch_strobe && !pl_q && byte_sel_lo) pb[alo] <= {dhi, dlo};
        if (!write_n && wn_q) begin
            busy <= BUSY;
            for (int i = 0; i < 256; i++) begin
                if (cmd == 8'h10 && bs == 2'h0) fl[i] <= pb[i];
                if (cmd == 8'h11 && bs == 2'h0) ee[i] <= pb[i][7:0];
            end
            if (cmd == 8'h40) fuse[bs] <= dlo;
        end
        if (!aresetn) begin
            busy <= 0;
            cmd <= 8'h00;
        end
    end
endmodule // nvm_dev_model
`default_nettype wire

// ### dv/nvm_prog_host_assertions.sv
/* Pin checker for nvm_prog_host.
   Assumes binding to the top module with its pulse parameters. */
`timescale 1ns/10ps
`default_nettype none
module nvm_prog_host_assertions #(
    parameter int PULSE_CYCLES = 3,
    parameter int SETUP_CYCLES = 2,
    parameter int BUSY_WAIT_CYCLES = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic action_sel_hi,
    input wire logic action_sel_lo,
    input wire logic byte_sel_lo,
    input wire logic byte_sel_hi,
    input wire logic page_latch_strobe,
    input wire logic load_strobe,
    input wire logic write_n,
    input wire logic output_enable_n,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic ready_busy_out
);
    localparam int P = PULSE_CYCLES;
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_cmd_sel; $rose(load_strobe) && action_sel_hi && !action_sel_lo |-> !byte_sel_lo; endproperty
    a_cmd_sel: assert property (p_cmd_sel) else $error("command load with select set");
    property p_ld_hold; load_strobe |-> $stable({action_sel_hi, action_sel_lo, byte_sel_hi, byte_sel_lo, data_out}); endproperty
    a_ld_hold: assert property (p_ld_hold) else $error("pins moved during load");
    property p_ld_drive; load_strobe |-> data_oe && output_enable_n; endproperty
    a_ld_drive: assert property (p_ld_drive) else $error("bus not driven during load");
    property p_ld_width; $rose(load_strobe) |-> ##P $fell(load_strobe); endproperty
    a_ld_width: assert property (p_ld_width) else $error("load pulse width");
    property p_latch_sel; page_latch_strobe |-> byte_sel_lo && $stable(byte_sel_lo); endproperty
    a_latch_sel: assert property (p_latch_sel) else $error("latch select");
    property p_wr_sel; !write_n |-> $stable({byte_sel_hi, byte_sel_lo}) && output_enable_n; endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("select moved during write");
    property p_oe_bus; !output_enable_n |-> !data_oe; endproperty
    a_oe_bus: assert property (p_oe_bus) else $error("bus contention");
    property p_busy; !ready_busy_out |-> !$rose(load_strobe) && !$rose(page_latch_strobe) && !$fell(write_n); endproperty
    a_busy: assert property (p_busy) else $error("strobe while busy");
endmodule // nvm_prog_host_assertions
bind nvm_prog_host nvm_prog_host_assertions #(.PULSE_CYCLES(PULSE_CYCLES), .SETUP_CYCLES(SETUP_CYCLES),
    .BUSY_WAIT_CYCLES(BUSY_WAIT_CYCLES)) u_chk (.aclk, .aresetn, .action_sel_hi, .action_sel_lo, .byte_sel_lo,
    .byte_sel_hi, .page_latch_strobe, .load_strobe, .write_n, .output_enable_n, .data_out, .data_oe, .ready_busy_out);
`default_nettype wire

// ### dv/nvm_prog_host_tb.sv
/* Testbench for nvm_prog_host: AXI4-Lite tasks, device model on the pins.
   Assumes a 100 MHz clock and the host register map. */
`timescale 1ns/10ps
`default_nettype none
module nvm_prog_host_tb;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, data_oe, ready_busy_out;
    logic action_sel_hi, action_sel_lo, byte_sel_lo, byte_sel_hi, page_latch_strobe, load_strobe, write_n;
    logic output_enable_n;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] data_in, data_out;
    int mismatches = 0, compares = 0, cyc = 0;
    nvm_prog_host #(.PULSE_CYCLES(3), .SETUP_CYCLES(2), .BUSY_WAIT_CYCLES(2)) u_dut (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .action_sel_hi, .action_sel_lo, .byte_sel_lo, .byte_sel_hi,
        .page_latch_strobe, .load_strobe, .write_n, .output_enable_n, .data_in, .data_out, .data_oe, .ready_busy_out);
    nvm_dev_model #(.BUSY(20)) u_dev (.aclk, .aresetn, .action_sel_hi, .action_sel_lo, .byte_sel_lo, .byte_sel_hi,
        .page_latch_strobe, .load_strobe, .write_n, .output_enable_n, .data_out, .data_in, .ready_busy_out);
    initial forever #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // Handshakes are judged on settled values half a cycle before the edge that takes them
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic aw_ok, w_ok, b_ok;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            b_ok = s_axi_bvalid === 1'b1;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end while (!b_ok);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] q);
        logic ar_ok, r_ok;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar_ok = s_axi_arvalid && s_axi_arready;
            r_ok = s_axi_rvalid === 1'b1;
            v = s_axi_rdata;
            q = s_axi_rresp;
            @(posedge aclk);
            if (ar_ok) s_axi_arvalid <= 1'b0;
        end while (!r_ok);
        s_axi_rready <= 1'b0;
    endtask
    task automatic op(input logic [2:0] o, input logic [1:0] s, input logic [7:0] b);
        logic [31:0] v;
        logic [1:0] q;
        wr(4'h0, {8'h00, b, 6'h00, s, 1'b0, o, 4'h1});
        do rd(4'h8, v, q); while (v[1] !== 1'b1);
        chk("error", v[2], 1'b0);
    endtask
    task automatic rdop(input logic s, input logic [7:0] e);
        op(3'h5, {1'b0, s}, 8'h00);
        rd(4'h4, d, r);
        chk("rbyte", d[7:0], e);
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h8, d, r);
        chk("stat", d, 32'h8);
        rd(4'hc, d, r);
        chk("resp", r, 2'h2);
        chk("rdata", d, 32'h0);
        $display("test reset done");
        op(3'h0, 2'h0, 8'h10);
        for (int i = 0; i < 2; i++) begin
            op(3'h1, 2'h0, 8'h05 + 8'(i));
            op(3'h2, 2'h0, 8'ha5 + 8'(i));
            op(3'h2, 2'h1, 8'h3c);
            op(3'h3, 2'h1, 8'h00);
        end
        op(3'h1, 2'h1, 8'h00);
        op(3'h1, 2'h2, 8'h00);
        op(3'h4, 2'h0, 8'h00);
        op(3'h0, 2'h0, 8'h00);
        rd(4'h4, d, r);
        chk("cmd", d[15:8], 8'h00);
        op(3'h0, 2'h0, 8'h02);
        for (int i = 0; i < 2; i++) begin
            op(3'h1, 2'h0, 8'h05 + 8'(i));
            rdop(1'b0, 8'ha5 + 8'(i));
            rdop(1'b1, 8'h3c);
        end
        $display("test flash done");
        op(3'h0, 2'h0, 8'h11);
        op(3'h1, 2'h1, 8'h00);
        op(3'h1, 2'h0, 8'h07);
        op(3'h2, 2'h0, 8'h5a);
        op(3'h3, 2'h1, 8'h00);
        op(3'h4, 2'h0, 8'h00);
        op(3'h0, 2'h0, 8'h03);
        rdop(1'b0, 8'h5a);
        $display("test eeprom done");
        op(3'h0, 2'h0, 8'h40);
        for (int i = 0; i < 3; i++) begin
            op(3'h2, 2'h0, 8'he0 + 8'(i));
            op(3'h4, 2'(i), 8'h00);
            chk("fuse", u_dev.fuse[i], 8'he0 + 8'(i));
        end
        $display("test fuse done");
        conclude();
    end
endmodule // nvm_prog_host_tb
`default_nettype wire

// ### hdl/nvm_prog_consts.vh
/*
 Constants for the parallel programming port controller: register map,
 pin action codes, device command bytes and pulse timing.
 Assumes inclusion by bare name from the controller file.
*/
`ifndef NVM_PROG_CONSTS_VH
`define NVM_PROG_CONSTS_VH

// Register byte offsets
`define REG_CTRL 4'h0
`define REG_DATA 4'h4
`define REG_STAT 4'h8

// Control register fields
`define CTRL_GO_BIT 0
`define CTRL_OP_LSB 4
`define CTRL_OP_MSB 6
`define CTRL_SEL_LSB 8
`define CTRL_SEL_MSB 9
`define CTRL_BYTE_LSB 16
`define CTRL_BYTE_MSB 23

// Operations requested by software
`define OP_LOAD_CMD 3'h0
`define OP_LOAD_ADDR 3'h1
`define OP_LOAD_DATA 3'h2
`define OP_LATCH 3'h3
`define OP_WRITE 3'h4
`define OP_READ 3'h5

// Action select codes
`define ACT_ADDR 2'h0
`define ACT_DATA 2'h1
`define ACT_CMD 2'h2
`define ACT_IDLE 2'h3

// Device command bytes
`define CMD_NOP 8'h00
`define CMD_READ_FLASH 8'h02
`define CMD_READ_EEPROM 8'h03
`define CMD_WRITE_FLASH 8'h10
`define CMD_WRITE_EEPROM 8'h11
`define CMD_WRITE_FUSE 8'h40

// Byte select pair codes
`define BSEL_LOW 2'h0
`define BSEL_HIGH 2'h1
`define BSEL_EXT 2'h2

// Pulse timing in ns and in cycles at 10 ns
`define CLK_PERIOD_NS 10
`define PULSE_NS 250
`define PULSE_CYC ((`PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_NS 67
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_WAIT_NS 1000
`define BUSY_WAIT_CYC ((`BUSY_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### hdl/nvm_prog_host.v
/*
 Host controller for a parallel flash/EEPROM/fuse programming port.
 Software writes a control word over AXI4-Lite; the controller sets the
 select pins, drives the data bus unless reading and gives one timed strobe, then reports.
 Assumes the device is already in programming mode and pins are synchronous.
*/
`timescale 1ns/10ps
`default_nettype none
`include "nvm_prog_consts.vh"

module nvm_prog_host #(
    parameter PULSE_CYCLES = `PULSE_CYC,
    parameter SETUP_CYCLES = `SETUP_CYC,
    parameter BUSY_WAIT_CYCLES = `BUSY_WAIT_CYC
) (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg action_sel_hi,
    output reg action_sel_lo,
    output reg byte_sel_lo,
    output reg byte_sel_hi,
    output reg page_latch_strobe,
    output reg load_strobe,
    output reg write_n,
    output reg output_enable_n,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe,
    input wire ready_busy_out
);

    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_SETUP = 5'h02;
    localparam [4:0] ST_PULSE = 5'h04;
    localparam [4:0] ST_HOLD = 5'h08;
    localparam [4:0] ST_WAIT = 5'h10;

    reg [4:0] state_q;
    reg [2:0] op_q;
    reg [1:0] sel_q;
    reg [7:0] byte_q;
    reg [7:0] read_q;
    reg [7:0] last_cmd_q;
    reg [15:0] cnt_q;
    reg busy_q;
    reg done_q;
    reg err_q;
    reg aw_held_q;
    reg w_held_q;
    reg [3:0] awaddr_q;
    reg [31:0] wdata_q;

    wire aw_take = s_axi_awvalid && !aw_held_q && !s_axi_bvalid;
    wire w_take = s_axi_wvalid && !w_held_q && !s_axi_bvalid;
    wire have_aw = aw_held_q || aw_take;
    wire have_w = w_held_q || w_take;
    wire [3:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
    wire wr_fire = have_aw && have_w && !s_axi_bvalid;
    wire go = wr_fire && wr_addr == `REG_CTRL && wr_data[`CTRL_GO_BIT] && s_axi_wstrb[0];
    wire [2:0] go_op = wr_data[`CTRL_OP_MSB:`CTRL_OP_LSB];

    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // Action select pair for a load-strobe operation
    function [1:0] act_of;
        input [2:0] op;
        begin
            case (op)
                `OP_LOAD_CMD: act_of = `ACT_CMD;
                `OP_LOAD_ADDR: act_of = `ACT_ADDR;
                `OP_LOAD_DATA: act_of = `ACT_DATA;
                default: act_of = `ACT_IDLE;
            endcase
        end
    endfunction

    // Byte select pair for the operation
    function [1:0] sel_of;
        input [2:0] op;
        input [1:0] sel;
        begin
            if (op == `OP_LOAD_CMD) begin
                sel_of = `BSEL_LOW;
            end else if (op == `OP_LATCH) begin
                sel_of = `BSEL_HIGH;
            end else if (op == `OP_LOAD_DATA || op == `OP_READ) begin
                sel_of = {1'b0, sel[0]};
            end else begin
                sel_of = sel;
            end
        end
    endfunction

    // Register write path
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_addr == `REG_CTRL || wr_addr == `REG_DATA || wr_addr == `REG_STAT) begin
                    s_axi_bresp <= 2'h0;
                end else begin
                    s_axi_bresp <= 2'h2;
                end
            end else begin
                if (aw_take) begin
                    aw_held_q <= 1'b1;
                    awaddr_q <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held_q <= 1'b1;
                    wdata_q <= s_axi_wdata;
                end
            end
        end
    end

    // Register read path
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            if (s_axi_araddr == `REG_CTRL) begin
                s_axi_rdata <= {8'h0, byte_q, 6'h0, sel_q, 1'b0, op_q, 4'h0};
            end else if (s_axi_araddr == `REG_DATA) begin
                s_axi_rdata <= {16'h0, last_cmd_q, read_q};
            end else if (s_axi_araddr == `REG_STAT) begin
                s_axi_rdata <= {28'h0, ready_busy_out, err_q, done_q, busy_q};
            end else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= 2'h2;
            end
        end
    end

    // Pin sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            op_q <= `OP_LOAD_CMD;
            sel_q <= 2'h0;
            byte_q <= 8'h0;
            read_q <= 8'h0;
            last_cmd_q <= `CMD_NOP;
            cnt_q <= 16'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            action_sel_hi <= 1'b1;
            action_sel_lo <= 1'b1;
            byte_sel_lo <= 1'b0;
            byte_sel_hi <= 1'b0;
            page_latch_strobe <= 1'b0;
            load_strobe <= 1'b0;
            write_n <= 1'b1;
            output_enable_n <= 1'b1;
            data_out <= 8'h0;
            data_oe <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        op_q <= go_op;
                        sel_q <= wr_data[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
                        byte_q <= wr_data[`CTRL_BYTE_MSB:`CTRL_BYTE_LSB];
                        busy_q <= 1'b1;
                        done_q <= 1'b0;
                        err_q <= !ready_busy_out;
                        {action_sel_hi, action_sel_lo} <= act_of(go_op);
                        {byte_sel_hi, byte_sel_lo} <= sel_of(go_op, wr_data[`CTRL_SEL_MSB:`CTRL_SEL_LSB]);
                        data_out <= wr_data[`CTRL_BYTE_MSB:`CTRL_BYTE_LSB];
                        data_oe <= go_op != `OP_READ;
                        if (go_op == `OP_LOAD_CMD) begin
                            last_cmd_q <= wr_data[`CTRL_BYTE_MSB:`CTRL_BYTE_LSB];
                        end
                        cnt_q <= SETUP_CYCLES[15:0];
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cnt_q <= 16'h1) begin
                        cnt_q <= PULSE_CYCLES[15:0];
                        state_q <= ST_PULSE;
                        if (op_q == `OP_LATCH) begin
                            page_latch_strobe <= 1'b1;
                        end else if (op_q == `OP_WRITE) begin
                            write_n <= 1'b0;
                        end else if (op_q == `OP_READ) begin
                            output_enable_n <= 1'b0;
                        end else begin
                            load_strobe <= 1'b1;
                        end
                    end else begin
                        cnt_q <= cnt_q - 16'h1;
                    end
                end
                ST_PULSE: begin
                    if (cnt_q <= 16'h1) begin
                        if (op_q == `OP_READ) begin
                            read_q <= data_in;
                        end
                        page_latch_strobe <= 1'b0;
                        load_strobe <= 1'b0;
                        write_n <= 1'b1;
                        output_enable_n <= 1'b1;
                        cnt_q <= (op_q == `OP_WRITE) ? BUSY_WAIT_CYCLES[15:0] : PULSE_CYCLES[15:0];
                        state_q <= (op_q == `OP_WRITE) ? ST_WAIT : ST_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 16'h1;
                    end
                end
                ST_WAIT: begin
                    if (cnt_q > 16'h1) begin
                        cnt_q <= cnt_q - 16'h1;
                    end else if (ready_busy_out) begin
                        cnt_q <= PULSE_CYCLES[15:0];
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (cnt_q <= 16'h1) begin
                        data_oe <= 1'b0;
                        action_sel_hi <= 1'b1;
                        action_sel_lo <= 1'b1;
                        {byte_sel_hi, byte_sel_lo} <= `BSEL_LOW;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 16'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // nvm_prog_host
`default_nettype wire
